/* File: pkg/role_session_params.svh */
// constants for the role and session controller
`ifndef ROLE_SESSION_PARAMS_SVH
`define ROLE_SESSION_PARAMS_SVH
`define MGMT_ROLE_W      3
`define PATH_ROLE_W      2
`define ACCESS_W         2
`define KEY_SEL_NONE     2'h0
`define KEY_SEL_CURRENT  2'h1
`define KEY_SEL_MIGRATE  2'h2
`endif

/* File: pkg/role_session_pkg.sv */
// types shared by the role and session controller
package role_session_pkg;
   // management side roles
   typedef enum logic [2:0] {
      MGMT_NONE      = 3'b000,
      MGMT_INIT      = 3'b001,
      MGMT_ADMIN     = 3'b010,
      MGMT_MANAGER   = 3'b011,
      MGMT_USER      = 3'b100
   } mgmt_role_t;
   // datapath roles
   typedef enum logic [1:0] {
      PATH_NONE      = 2'b00,
      PATH_SECURE    = 2'b01,
      PATH_MIGRATE   = 2'b10,
      PATH_PREBOOT   = 2'b11
   } path_role_t;
   // session commands decoded from the host command stream
   typedef enum logic [3:0] {
      CMD_NOP          = 4'h0,
      CMD_LOGIN_INIT   = 4'h1,
      CMD_LOGIN_OP     = 4'h2,
      CMD_LOGOUT_MGMT  = 4'h3,
      CMD_BOOT_LEAVE   = 4'h4,
      CMD_BOOT_STAY    = 4'h5,
      CMD_MIGRATE      = 4'h6,
      CMD_UNLOCK_PRE   = 4'h7,
      CMD_LOGOUT_PATH  = 4'h8,
      CMD_AUTO_AUTH    = 4'h9,
      CMD_CREATE_ADMIN = 4'hA
   } cmd_t;
endpackage

/* File: pkg/drive_gate_if.sv */
// carrier between session controller and drive access gate
interface drive_gate_if;
   logic [1:0] pathRole;
   logic       allowRead;
   logic       allowWrite;
   logic [1:0] decKeySel;
   logic [1:0] encKeySel;
   modport ctrl (output pathRole, input allowRead, allowWrite, decKeySel, encKeySel);
   modport gate (input pathRole, output allowRead, allowWrite, decKeySel, encKeySel);
endinterface

/* File: hdl/drive_access_gate.sv */
// drive region gating and key selection from the datapath role
`include "role_session_params.svh"
module drive_access_gate (
   drive_gate_if.gate gi,
   input  wire logic  preboot_region
);
   // ************************************************
   // access decision for one drive request
   // ************************************************
   always_comb begin
      gi.allowRead  = 1'b0;
      gi.allowWrite = 1'b0;
      gi.decKeySel  = `KEY_SEL_NONE;
      gi.encKeySel  = `KEY_SEL_NONE;
      case (role_session_pkg::path_role_t'(gi.pathRole))
         role_session_pkg::PATH_SECURE: begin
            gi.allowRead  = !preboot_region;
            gi.allowWrite = !preboot_region;
            gi.decKeySel  = `KEY_SEL_CURRENT;
            gi.encKeySel  = `KEY_SEL_CURRENT;
         end
         role_session_pkg::PATH_MIGRATE: begin
            gi.allowRead  = !preboot_region;
            gi.allowWrite = !preboot_region;
            gi.decKeySel  = `KEY_SEL_MIGRATE;  // old key on reads
            gi.encKeySel  = `KEY_SEL_CURRENT;  // new key on writes
         end
         role_session_pkg::PATH_PREBOOT: begin
            gi.allowRead  = preboot_region;
            gi.allowWrite = preboot_region;
            gi.decKeySel  = `KEY_SEL_CURRENT;
            gi.encKeySel  = `KEY_SEL_CURRENT;
         end
         default: begin
            gi.allowRead  = preboot_region;    // read only
            gi.decKeySel  = `KEY_SEL_CURRENT;
         end
      endcase
   end
endmodule // drive_access_gate

/* File: hdl/datapath_role_session_control.sv */
// role and session controller for the encrypting datapath
`include "role_session_params.svh"
module datapath_role_session_control (
   input  wire logic        core_clk,
   input  wire logic        rstn,
   input  wire logic        approvedMode,
   input  wire logic        accountsExist,
   input  wire logic        cmdValid,
   input  wire logic [3:0]  cmdCode,
   input  wire logic [2:0]  cmdLoginRole,
   input  wire logic        cmdAuthOk,
   input  wire logic        errorEvent,
   input  wire logic        preboot_region,
   output logic             cmdAccept,
   output logic             cmdReject,
   output logic [2:0]       management_side,
   output logic [1:0]       encrypting_datapath,
   output logic             initDone,
   output logic             createAdminPulse,
   output logic             driveReadAllow,
   output logic             driveWriteAllow,
   output logic [1:0]       decKeySel,
   output logic [1:0]       encKeySel
);
   // ************************************************
   // state
   // ************************************************
   role_session_pkg::mgmt_role_t mgmtRole;
   role_session_pkg::mgmt_role_t next_mgmtRole;
   role_session_pkg::path_role_t pathRole;
   role_session_pkg::path_role_t next_pathRole;
   logic                         adminCreated;
   logic                         next_adminCreated;
   logic                         next_initDone;
   logic                         next_createAdminPulse;
   logic                         next_cmdAccept;
   logic                         next_cmdReject;
   logic                         ok;
   role_session_pkg::cmd_t       cmd;
   role_session_pkg::mgmt_role_t reqRole;
   drive_gate_if                 gateBus ();

   assign cmd     = role_session_pkg::cmd_t'(cmdCode);
   assign reqRole = role_session_pkg::mgmt_role_t'(cmdLoginRole);

   // ************************************************
   // session state next values
   // ************************************************
   always_comb begin
      next_mgmtRole         = mgmtRole;
      next_pathRole         = pathRole;
      next_adminCreated     = adminCreated;
      next_initDone         = initDone;
      next_createAdminPulse = 1'b0;
      ok                    = 1'b0;
      if (cmdValid) begin
         case (cmd)
            role_session_pkg::CMD_LOGIN_INIT: begin
               // initializer only while no accounts, both sides idle
               ok = !accountsExist && cmdAuthOk
                    && mgmtRole == role_session_pkg::MGMT_NONE
                    && pathRole == role_session_pkg::PATH_NONE;
               if (ok) next_mgmtRole = role_session_pkg::MGMT_INIT;
            end
            role_session_pkg::CMD_LOGIN_OP: begin
               ok = accountsExist && cmdAuthOk
                    && mgmtRole == role_session_pkg::MGMT_NONE
                    && (reqRole == role_session_pkg::MGMT_ADMIN
                        || reqRole == role_session_pkg::MGMT_MANAGER
                        || reqRole == role_session_pkg::MGMT_USER);
               if (ok) next_mgmtRole = reqRole;
            end
            role_session_pkg::CMD_LOGOUT_MGMT: begin
               ok            = mgmtRole != role_session_pkg::MGMT_NONE;
               next_mgmtRole = role_session_pkg::MGMT_NONE;
            end
            role_session_pkg::CMD_BOOT_LEAVE,
            role_session_pkg::CMD_BOOT_STAY: begin
               // no new credentials needed from a held role
               ok = mgmtRole != role_session_pkg::MGMT_NONE
                    && mgmtRole != role_session_pkg::MGMT_INIT
                    && pathRole == role_session_pkg::PATH_NONE;
               if (ok) begin
                  next_pathRole = role_session_pkg::PATH_SECURE;
                  if (cmd == role_session_pkg::CMD_BOOT_LEAVE)
                     next_mgmtRole = role_session_pkg::MGMT_NONE;
               end
            end
            role_session_pkg::CMD_MIGRATE,
            role_session_pkg::CMD_UNLOCK_PRE: begin
               ok = mgmtRole == role_session_pkg::MGMT_ADMIN
                    && pathRole == role_session_pkg::PATH_NONE;
               if (ok) begin
                  if (cmd == role_session_pkg::CMD_MIGRATE)
                     next_pathRole = role_session_pkg::PATH_MIGRATE;
                  else
                     next_pathRole = role_session_pkg::PATH_PREBOOT;
               end
            end
            role_session_pkg::CMD_LOGOUT_PATH: begin
               ok            = pathRole != role_session_pkg::PATH_NONE;
               next_pathRole = role_session_pkg::PATH_NONE;
            end
            role_session_pkg::CMD_AUTO_AUTH: begin
               // never in approved mode, never past a held role
               ok = !approvedMode
                    && pathRole == role_session_pkg::PATH_NONE
                    && mgmtRole == role_session_pkg::MGMT_NONE;
               if (ok) next_pathRole = role_session_pkg::PATH_SECURE;
            end
            role_session_pkg::CMD_CREATE_ADMIN: begin
               ok = mgmtRole == role_session_pkg::MGMT_INIT && !adminCreated;
               if (ok) begin
                  next_adminCreated     = 1'b1;
                  next_initDone         = 1'b1;
                  next_createAdminPulse = 1'b1;
               end
            end
            default: ok = 1'b0;
         endcase
      end
      // error overrides everything
      if (errorEvent) begin
         next_mgmtRole = role_session_pkg::MGMT_NONE;
         next_pathRole = role_session_pkg::PATH_NONE;
         ok            = 1'b0;
         next_createAdminPulse = 1'b0;
         next_adminCreated     = adminCreated;
         next_initDone         = initDone;
      end
      next_cmdAccept = cmdValid && ok;
      next_cmdReject = cmdValid && !ok;
   end

   // ************************************************
   // session state registers
   // ************************************************
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         mgmtRole         <= role_session_pkg::MGMT_NONE;
         pathRole         <= role_session_pkg::PATH_NONE;
         adminCreated     <= 1'b0;
         initDone         <= 1'b0;
         createAdminPulse <= 1'b0;
         cmdAccept        <= 1'b0;
         cmdReject        <= 1'b0;
      end else begin
         mgmtRole         <= next_mgmtRole;
         pathRole         <= next_pathRole;
         adminCreated     <= next_adminCreated;
         initDone         <= next_initDone;
         createAdminPulse <= next_createAdminPulse;
         cmdAccept        <= next_cmdAccept;
         cmdReject        <= next_cmdReject;
      end
   end

   // ************************************************
   // role outputs and drive gate
   // ************************************************
   assign management_side     = mgmtRole;
   assign encrypting_datapath = pathRole;
   assign gateBus.pathRole    = pathRole;
   assign driveReadAllow      = gateBus.allowRead;
   assign driveWriteAllow     = gateBus.allowWrite;
   assign decKeySel           = gateBus.decKeySel;
   assign encKeySel           = gateBus.encKeySel;

   drive_access_gate u_gate (
      .gi             (gateBus.gate),
      .preboot_region (preboot_region)
   );
endmodule // datapath_role_session_control

/* File: verification/datapath_role_session_chk.sv */
// assertion checker for the role and session controller
module datapath_role_session_chk (
   input wire logic       core_clk,
   input wire logic       rstn,
   input wire logic       approvedMode,
   input wire logic       accountsExist,
   input wire logic       cmdValid,
   input wire logic [3:0] cmdCode,
   input wire logic       errorEvent,
   input wire logic       preboot_region,
   input wire logic       cmdReject,
   input wire logic [2:0] management_side,
   input wire logic [1:0] encrypting_datapath,
   input wire logic       driveWriteAllow,
   input wire logic       driveReadAllow,
   input wire logic [1:0] decKeySel,
   input wire logic [1:0] encKeySel
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // ****************************************
   // session and access properties
   // ****************************************
   a_reset_no_role: assert property (disable iff (1'b0) !rstn |=>
      management_side == 3'h0 && encrypting_datapath == 2'h0) else $error("roles kept in reset");
   a_error_clears_all: assert property (errorEvent |=>
      management_side == 3'h0 && encrypting_datapath == 2'h0) else $error("error kept a role");
   a_path_via_none: assert property ($past(encrypting_datapath) != 2'h0 &&
      encrypting_datapath != $past(encrypting_datapath) |-> encrypting_datapath == 2'h0)
      else $error("path role changed directly");
   a_mgmt_via_none: assert property ($past(management_side) != 3'h0 &&
      management_side != $past(management_side) |-> management_side == 3'h0)
      else $error("management role changed directly");
   a_admin_only_entry: assert property ($past(encrypting_datapath) == 2'h0 &&
      encrypting_datapath[1] |-> $past(management_side) == 3'h2) else $error("entry without admin");
   a_secure_entry_gate: assert property ($past(encrypting_datapath) == 2'h0 &&
      encrypting_datapath == 2'h1 && $past(approvedMode) |->
      $past(management_side) inside {3'h2, 3'h3, 3'h4}) else $error("secure entry illegal");
   a_both_busy_login: assert property (cmdValid && !errorEvent && cmdCode inside {4'h1, 4'h2} &&
      management_side != 3'h0 && encrypting_datapath != 2'h0 |=> cmdReject)
      else $error("login taken while both busy");
   a_auto_blocked: assert property (cmdValid && cmdCode == 4'h9 && approvedMode && !errorEvent
      |=> cmdReject ##0 $stable(encrypting_datapath)) else $error("auto entry in approved mode");
   a_login_accounts: assert property (cmdValid && (cmdCode == 4'h1 && accountsExist ||
      cmdCode == 4'h2 && !accountsExist) |=> cmdReject) else $error("login against accounts");
   a_migrate_keys: assert property (encrypting_datapath == 2'h2 |->
      decKeySel == 2'h2 && encKeySel == 2'h1) else $error("migration key select wrong");
   a_idle_read_only: assert property (encrypting_datapath == 2'h0 |-> !driveWriteAllow &&
      driveReadAllow == preboot_region) else $error("idle access not read only");
   c_migrate: cover property ($rose(encrypting_datapath == 2'h2));
   c_busy_reject: cover property (management_side != 3'h0 && encrypting_datapath != 2'h0 ##1 cmdReject);
   c_error: cover property (errorEvent && encrypting_datapath != 2'h0);
endmodule // datapath_role_session_chk
bind datapath_role_session_control datapath_role_session_chk i_chk (.core_clk(core_clk),
   .rstn(rstn), .approvedMode(approvedMode), .accountsExist(accountsExist), .cmdValid(cmdValid),
   .cmdCode(cmdCode), .errorEvent(errorEvent), .preboot_region(preboot_region),
   .cmdReject(cmdReject), .management_side(management_side), .driveReadAllow(driveReadAllow),
   .encrypting_datapath(encrypting_datapath), .driveWriteAllow(driveWriteAllow),
   .decKeySel(decKeySel), .encKeySel(encKeySel));

/* File: verification/drive_host_model.sv */
// far side model: host walking the drive sectors in turn
module drive_host_model #(parameter int SECTORS = 8, parameter int PRE_SECTORS = 2) (
   input  wire logic core_clk,
   input  wire logic rstn,
   output logic      preboot_region
);
   timeunit 1ns;
   timeprecision 1ns;
   int sector;
   // sweep every sector, the first few being the preboot region
   always @(posedge core_clk) begin
      if (!rstn || sector == SECTORS - 1) sector <= 0;
      else sector <= sector + 1;
   end
   assign preboot_region = sector < PRE_SECTORS;
endmodule // drive_host_model

/* File: verification/datapath_role_session_control_tb.sv */
// self-checking bench for the role and session controller
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
   $display("BAD %0t got %0h want %0h", $time, g, e); end end
module datapath_role_session_control_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk = 0, rstn = 0, approvedMode = 1, accountsExist = 0, cmdValid = 0;
   logic cmdAuthOk = 1, errorEvent = 0, preboot_region, cmdAccept, cmdReject, initDone;
   logic createAdminPulse, driveReadAllow, driveWriteAllow;
   logic [3:0] cmdCode = 4'h0;
   logic [2:0] cmdLoginRole = 3'h0, management_side;
   logic [1:0] encrypting_datapath, decKeySel, encKeySel;
   int         fail_count = 0, compares = 0;
   // ****************************************
   // clock, device and far side
   // ****************************************
   initial begin
      forever #5 core_clk = !core_clk;
   end
   datapath_role_session_control i_dut (.core_clk(core_clk), .rstn(rstn),
      .approvedMode(approvedMode), .accountsExist(accountsExist), .cmdValid(cmdValid),
      .cmdCode(cmdCode), .cmdLoginRole(cmdLoginRole), .cmdAuthOk(cmdAuthOk),
      .errorEvent(errorEvent), .preboot_region(preboot_region), .cmdAccept(cmdAccept),
      .cmdReject(cmdReject), .management_side(management_side), .initDone(initDone),
      .encrypting_datapath(encrypting_datapath), .createAdminPulse(createAdminPulse),
      .driveReadAllow(driveReadAllow), .driveWriteAllow(driveWriteAllow),
      .decKeySel(decKeySel), .encKeySel(encKeySel));
   drive_host_model i_host (.core_clk(core_clk), .rstn(rstn), .preboot_region(preboot_region));
   // one command, then answer and both roles judged
   task automatic op(input logic [3:0] c, input logic [2:0] r, input logic ok,
                     input logic [2:0] m, input logic [1:0] p);
      @(negedge core_clk);
      cmdCode = c;
      cmdLoginRole = r;
      cmdValid = 1'b1;
      @(negedge core_clk);
      cmdValid = 1'b0;
      `CHK({cmdAccept, cmdReject}, {ok, !ok})
      `CHK({management_side, encrypting_datapath}, {m, p})
   endtask
   // drive access and key choice across a sector sweep
   task automatic gate(input logic [1:0] p);
      repeat (8) begin
         @(negedge core_clk);
         `CHK(driveReadAllow, (p == 2'h0 || p == 2'h3) ? preboot_region : !preboot_region)
         `CHK(driveWriteAllow, p == 2'h3 ? preboot_region : (p != 2'h0 && !preboot_region))
         if (p == 2'h2) `CHK({decKeySel, encKeySel}, 4'h9)
         if (p == 2'h1) `CHK({decKeySel, encKeySel}, 4'h5)
      end
   endtask
   task automatic t_init;
      gate(2'h0);
      `CHK({management_side, encrypting_datapath, initDone}, 6'h00)
      op(4'h2, 3'h2, 0, 3'h0, 2'h0);
      op(4'h1, 3'h0, 1, 3'h1, 2'h0);
      op(4'h4, 3'h0, 0, 3'h1, 2'h0);
      op(4'h5, 3'h0, 0, 3'h1, 2'h0);
      op(4'hA, 3'h0, 1, 3'h1, 2'h0);
      `CHK({createAdminPulse, initDone}, 2'h3)
      op(4'hA, 3'h0, 0, 3'h1, 2'h0);
      op(4'h3, 3'h0, 1, 3'h0, 2'h0);
      op(4'h3, 3'h0, 0, 3'h0, 2'h0);
   endtask
   task automatic t_admin;
      accountsExist = 1'b1;
      op(4'h1, 3'h0, 0, 3'h0, 2'h0);
      op(4'h2, 3'h2, 1, 3'h2, 2'h0);
      op(4'h2, 3'h3, 0, 3'h2, 2'h0);
      op(4'h6, 3'h0, 1, 3'h2, 2'h2);
      gate(2'h2);
      op(4'h7, 3'h0, 0, 3'h2, 2'h2);
      op(4'h2, 3'h4, 0, 3'h2, 2'h2);
      op(4'h8, 3'h0, 1, 3'h2, 2'h0);
      op(4'h7, 3'h0, 1, 3'h2, 2'h3);
      gate(2'h3);
      op(4'h8, 3'h0, 1, 3'h2, 2'h0);
      op(4'h5, 3'h0, 1, 3'h2, 2'h1);
      gate(2'h1);
      op(4'h3, 3'h0, 1, 3'h0, 2'h1);
      op(4'h2, 3'h4, 1, 3'h4, 2'h1);
      op(4'h1, 3'h0, 0, 3'h4, 2'h1);
      @(negedge core_clk);
      errorEvent = 1'b1;
      @(negedge core_clk);
      errorEvent = 1'b0;
      `CHK({management_side, encrypting_datapath}, 5'h00)
   endtask
   task automatic t_user;
      op(4'h2, 3'h3, 1, 3'h3, 2'h0);
      op(4'h6, 3'h0, 0, 3'h3, 2'h0);
      op(4'h7, 3'h0, 0, 3'h3, 2'h0);
      op(4'h4, 3'h0, 1, 3'h0, 2'h1);
      op(4'h8, 3'h0, 1, 3'h0, 2'h0);
      cmdAuthOk = 1'b0;
      op(4'h2, 3'h4, 0, 3'h0, 2'h0);
      cmdAuthOk = 1'b1;
      op(4'h9, 3'h0, 0, 3'h0, 2'h0);
      approvedMode = 1'b0;
      op(4'h9, 3'h0, 1, 3'h0, 2'h1);
      approvedMode = 1'b1;
      op(4'h2, 3'h4, 1, 3'h4, 2'h1);
      rstn = 1'b0;
      repeat (2) @(negedge core_clk);
      rstn = 1'b1;
      `CHK({management_side, encrypting_datapath}, 5'h00)
   endtask
   task automatic complete_run;
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // main sequence after 20 cycles of reset
   initial begin
      repeat (20) @(negedge core_clk);
      rstn = 1'b1;
      t_init();
      t_admin();
      t_user();
      complete_run();
   end
   // watchdog well beyond the some 120 cycles the tests need
   initial begin
      #50000;
      fail_count++;
      complete_run();
   end
endmodule // datapath_role_session_control_tb
